// ==== core/cpu_fetch_sequencer_stack.sv ====
// instruction sequencer: phases, program counter, prefetch and return stack
//
// Notes on behaviour
// RQ1 - four phases form one instruction cycle
// RQ2 - pc advances and fetch happens in first phase
// RQ3 - fetch overlaps execution, one cycle each
// RQ4 - jumps and calls take two instruction cycles
// RQ5 - pc increments by one per instruction
// RQ6 - branches, interrupts, reset load pc directly
// RQ7 - taken skip discards prefetch, dummy cycle follows
// RQ8 - pc is 11 bits, low byte visible
// RQ9 - low byte write jumps within page, dummy
// RQ10 - four level stack, hidden from software
// RQ11 - call/interrupt push pc, returns pop it
// RQ12 - reset points stack pointer at top
// RQ13 - full stack holds interrupt until return
// RQ14 - call still executes on a full stack
// RQ15 - alu writes result and status flags
// RQ16 - alu offers arithmetic, logic, rotate, step ops
// RQ17 - overflowing call wraps, overwrites oldest entry
`timescale 1ns/1ps
`default_nettype none
module cpu_fetch_sequencer_stack (
    // clock and reset
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_sys_rst,
    // program memory fetch
    output logic      [seq_pkg::PC_W-1:0]      o_prog_addr,
    output logic                               o_fetch,
    output seq_pkg::phase_type                 o_phase,
    output logic                               o_dummy_cycle,
    // decoded instruction under execution
    input  wire seq_pkg::instr_type            i_instr,
    // interrupt request and acknowledge
    input  wire logic                          i_int_req,
    input  wire logic [seq_pkg::PC_W-1:0]      i_int_vector,
    output logic                               o_int_ack,
    output logic                               o_stack_overflow,
    // alu result
    output seq_pkg::alu_out_type               o_alu,
    // register port
    input  wire logic [7:0]                    i_reg_addr,
    input  wire logic [seq_pkg::DATA_W-1:0]    i_reg_wdata,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    output logic      [seq_pkg::DATA_W-1:0]    o_reg_rdata
);
    import seq_pkg::*;

    // whole sequencer state
    typedef struct packed {
        phase_type         phase;       // current phase
        logic [PC_W-1:0]   pc;          // next fetch address
        logic [PC_W-1:0]   fetch_addr;  // address of prefetched word
        logic              fetch;       // fetch strobe
        logic              dummy;       // execution slot is void
        logic              int_pend;    // latched interrupt request
        logic              int_ack;     // acknowledge pulse
        logic              pcl_pend;    // low byte write waiting
        logic [DATA_W-1:0] pcl_val;     // value written to low byte
        logic [SP_W-1:0]   sp;          // next free stack slot
        logic [2:0]        depth;       // occupied levels
        logic              ovf;         // overflow pulse
        alu_out_type       alu;         // registered alu result
        logic [DATA_W-1:0] rdata;       // register read data
    } state_type;

    state_type         st;         // registered state
    state_type         next_st;    // next state
    logic [PC_W-1:0]   pop_data;   // stack top read data
    logic              push;       // stack write this cycle
    logic [DATA_W-1:0] alu_data;   // alu result data
    logic              alu_carry;  // alu carry flag
    logic              alu_aux;    // alu half carry flag
    logic              alu_ovf;    // alu overflow flag
    logic              exec;       // live execution in last phase
    logic              pcl_wr;     // low byte write strobe

    // stack storage, hidden from the register port
    stack_mem u_stack (                                            // [RQ10]
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_wr      (push),
        .i_wr_addr (st.sp),
        .i_wr_data (st.fetch_addr),
        .i_rd_addr (st.sp - SP_STEP),
        .o_rd_data (pop_data)
    );

    // operation unit for alu class instructions
    alu_unit u_alu (                                               // [RQ16]
        .i_op    (i_instr.op),
        .i_a     (i_instr.a),
        .i_b     (i_instr.b),
        .i_carry (i_instr.carry_in),
        .o_data  (alu_data),
        .o_carry (alu_carry),
        .o_aux   (alu_aux),
        .o_ovf   (alu_ovf)
    );

    // execution happens in the last phase unless the slot is dummy
    assign exec   = (st.phase == PH_T4) && !st.dummy;
    assign pcl_wr = i_reg_wr && (i_reg_addr == ADDR_PCL);

    // next state of the whole sequencer
    always_comb begin
        next_st         = st;
        next_st.fetch   = 1'b0;
        next_st.int_ack = 1'b0;
        next_st.ovf     = 1'b0;
        next_st.alu     = '0;
        push            = 1'b0;
        // phase sequencer, wraps every four clocks
        case (st.phase)                                            // [RQ1]
            PH_T1:   next_st.phase = PH_T2;
            PH_T2:   next_st.phase = PH_T3;
            PH_T3:   next_st.phase = PH_T4;
            PH_T4:   next_st.phase = PH_T1;
            default: next_st.phase = PH_T1;
        endcase
        // fetch the next word and step the pc in the first phase
        if (st.phase == PH_T1) begin
            next_st.fetch_addr = st.pc;                            // [RQ2] [RQ3]
            next_st.fetch      = 1'b1;
            next_st.pc         = st.pc + PC_STEP;                  // [RQ5]
        end
        // latch interrupt request; set wins over ack clear
        if (i_int_req) begin
            next_st.int_pend = 1'b1;                               // [RQ13]
        end
        // hold a low byte write until the last phase
        if (pcl_wr) begin
            next_st.pcl_pend = 1'b1;
            next_st.pcl_val  = i_reg_wdata;
        end
        // last phase: execute, then settle the next slot
        if (st.phase == PH_T4) begin
            next_st.dummy = 1'b0;
            if (exec) begin
                case (i_instr.iclass)
                    I_JUMP: begin
                        // load target; prefetched word voided
                        next_st.pc    = i_instr.target;            // [RQ6]
                        next_st.dummy = 1'b1;                      // [RQ4]
                    end
                    I_CALL: begin
                        // push return address even when full
                        push          = 1'b1;                      // [RQ11] [RQ14]
                        next_st.sp    = st.sp + SP_STEP;           // [RQ17]
                        next_st.pc    = i_instr.target;            // [RQ6]
                        next_st.dummy = 1'b1;                      // [RQ4]
                        if (st.depth == STACK_FULL) begin
                            next_st.ovf = 1'b1;                    // [RQ17]
                        end else begin
                            next_st.depth = st.depth + DEPTH_STEP;
                        end
                    end
                    I_RET, I_INTERRUPT_RETURN: begin
                        // restore pc from the stack top
                        next_st.pc    = pop_data;                  // [RQ11]
                        next_st.dummy = 1'b1;
                        next_st.sp    = st.sp - SP_STEP;
                        if (st.depth != STACK_EMPTY) begin
                            next_st.depth = st.depth - DEPTH_STEP;
                        end
                    end
                    I_SKIP: begin
                        // taken skip voids the prefetched word
                        if (i_instr.skip_taken) begin
                            next_st.dummy = 1'b1;                  // [RQ7]
                        end
                    end
                    I_ALU: begin
                        // register result and flags
                        next_st.alu.valid  = 1'b1;                 // [RQ15]
                        next_st.alu.to_mem = i_instr.to_mem;
                        next_st.alu.data   = alu_data;
                        next_st.alu.carry  = alu_carry;
                        next_st.alu.aux    = alu_aux;
                        next_st.alu.zero   = (alu_data == ZERO_BYTE);
                        next_st.alu.ovf    = alu_ovf;
                    end
                    default: begin
                        // plain instruction, pc already stepped
                        next_st.dummy = 1'b0;
                    end
                endcase
            end
            // low byte write jumps inside the current page
            if (st.pcl_pend || pcl_wr) begin
                next_st.pc = {st.pc[PC_W-1:DATA_W],
                              pcl_wr ? i_reg_wdata : st.pcl_val};  // [RQ8] [RQ9]
                next_st.dummy    = 1'b1;                           // [RQ9]
                next_st.pcl_pend = 1'b0;
            end else if (exec && st.int_pend && (st.depth != STACK_FULL)
                         && (i_instr.iclass == I_NORMAL || i_instr.iclass == I_ALU
                             || (i_instr.iclass == I_SKIP && !i_instr.skip_taken))) begin
                // interrupt entry: push prefetched address, load vector
                push             = 1'b1;                           // [RQ11]
                next_st.sp       = st.sp + SP_STEP;
                next_st.depth    = st.depth + DEPTH_STEP;
                next_st.pc       = i_int_vector;                   // [RQ6]
                next_st.dummy    = 1'b1;
                next_st.int_ack  = 1'b1;
                next_st.int_pend = i_int_req;                      // [RQ13]
            end
        end
        // register read port, data one cycle later
        next_st.rdata = ZERO_BYTE;
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_PCL: next_st.rdata = st.pc[DATA_W-1:0];       // [RQ8]
                ADDR_STATUS: begin
                    next_st.rdata[STAT_PEND]  = st.int_pend;
                    next_st.rdata[STAT_OVF]   = st.ovf;
                    next_st.rdata[STAT_DUMMY] = st.dummy;
                end
                default: next_st.rdata = ZERO_BYTE;
            endcase
        end
    end

    // register the state; reset loads vector and empties stack
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st       <= '0;
            st.phase <= PH_T1;
            st.pc    <= RESET_VECTOR;                              // [RQ6]
            st.dummy <= 1'b1;
            st.sp    <= SP_TOP;                                    // [RQ12]
            st.depth <= STACK_EMPTY;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_prog_addr      = st.fetch_addr;
    assign o_fetch          = st.fetch;
    assign o_phase          = st.phase;
    assign o_dummy_cycle    = st.dummy;
    assign o_int_ack        = st.int_ack;
    assign o_stack_overflow = st.ovf;
    assign o_alu            = st.alu;
    assign o_reg_rdata      = st.rdata;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // phase order and fetch timing
    chk_phase_order: assert property (st.phase == PH_T1 |=> st.phase == PH_T2 ##1   // [RQ1]
        st.phase == PH_T3 ##1 st.phase == PH_T4 ##1 st.phase == PH_T1)
        else $error("phase order broken");
    chk_fetch_first: assert property (st.phase == PH_T1 |=> o_fetch  // [RQ2] [RQ5]
        && o_prog_addr == $past(st.pc) && st.pc == $past(st.pc) + PC_STEP)
        else $error("fetch or pc step wrong");
    chk_jump_target: assert property (exec && i_instr.iclass == I_JUMP  // [RQ4] [RQ6]
        && !pcl_wr && !st.pcl_pend |=> st.pc == $past(i_instr.target) && st.dummy)
        else $error("jump not taken");
    chk_skip_dummy: assert property (exec && i_instr.iclass == I_SKIP  // [RQ7]
        && i_instr.skip_taken |=> st.dummy ##4 !st.dummy)
        else $error("skip dummy slot wrong");
    chk_pcl_page: assert property (st.phase == PH_T4 && pcl_wr |=>  // [RQ9]
        st.pc == {$past(st.pc[PC_W-1:DATA_W]), $past(i_reg_wdata)} && st.dummy)
        else $error("low byte jump wrong");
    chk_full_no_ack: assert property (st.depth == STACK_FULL |=> !o_int_ack) // [RQ13]
        else $error("ack with full stack");
    chk_call_push: assert property (exec && i_instr.iclass == I_CALL && !pcl_wr  // [RQ11]
        && !st.pcl_pend && st.depth != STACK_FULL |=> st.depth == $past(st.depth) + DEPTH_STEP)
        else $error("call push depth wrong");
    chk_call_full: assert property (exec && i_instr.iclass == I_CALL  // [RQ14] [RQ17]
        && st.depth == STACK_FULL |=> o_stack_overflow && st.depth == STACK_FULL)
        else $error("overflowing call wrong");
    chk_reset_top: assert property (disable iff (1'b0) i_sys_rst |=>  // [RQ12]
        st.sp == SP_TOP && st.depth == STACK_EMPTY)
        else $error("stack pointer not at top");
    chk_alu_flags: assert property (exec && i_instr.iclass == I_ALU |=>  // [RQ15]
        o_alu.valid && o_alu.zero == (o_alu.data == ZERO_BYTE))
        else $error("alu result not flagged");
    // stack and pointer stay hidden behind the port
    chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr != ADDR_PCL  // [RQ10]
        && i_reg_addr != ADDR_STATUS |=> o_reg_rdata == ZERO_BYTE)
        else $error("unmapped read not zero");
    // plain words keep pace, returns pop, interrupts enter
    chk_plain_no_dummy: assert property (exec && i_instr.iclass == I_NORMAL  // [RQ3]
        && !st.int_pend && !pcl_wr && !st.pcl_pend |=> !st.dummy)
        else $error("plain word lost a cycle");
    chk_ret_pop: assert property (exec && i_instr.iclass == I_RET  // [RQ11]
        && st.depth != STACK_EMPTY |=> st.depth == $past(st.depth) - DEPTH_STEP)
        else $error("return did not pop");
    chk_int_entry: assert property (o_int_ack |-> st.pc == $past(i_int_vector)  // [RQ6] [RQ13]
        && st.dummy && st.depth != STACK_EMPTY)
        else $error("interrupt entry wrong");

    // main scenarios
    cov_jump:      cover property (exec && i_instr.iclass == I_JUMP);
    cov_int_ack:   cover property (o_int_ack);
    cov_overflow:  cover property (o_stack_overflow);
    cov_pcl_write: cover property (pcl_wr ##[1:4] st.dummy);
endmodule : cpu_fetch_sequencer_stack
`default_nettype wire

// ==== core/seq_pkg.sv ====
// shared constants and types for the instruction sequencer
package seq_pkg;
    // program counter and data widths
    localparam int PC_W    = 11;
    localparam int DATA_W  = 8;
    localparam int SP_W    = 2;
    // return stack levels
    localparam int STACK_LEVELS          = 4;
    localparam logic [2:0] STACK_FULL    = 3'h4;
    localparam logic [2:0] STACK_EMPTY   = 3'h0;
    localparam logic [SP_W-1:0] SP_TOP   = 2'h0;
    localparam logic [SP_W-1:0] SP_STEP  = 2'h1;
    localparam logic [2:0] DEPTH_STEP    = 3'h1;
    // pc reset value and increment
    localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
    localparam logic [PC_W-1:0] PC_STEP      = 11'h001;
    // register port offsets
    localparam logic [7:0] ADDR_PCL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    // status register bit positions
    localparam int STAT_PEND  = 0;
    localparam int STAT_OVF   = 1;
    localparam int STAT_DUMMY = 2;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // the four phases of one instruction cycle
    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_type;
    // instruction class from the external decoder
    typedef enum logic [2:0] {
        I_NORMAL, I_ALU, I_JUMP, I_CALL, I_RET, I_INTERRUPT_RETURN, I_SKIP
    } iclass_type;
    // alu operations
    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
        ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC
    } alu_op_type;
    // decoded instruction in execution
    typedef struct packed {
        iclass_type        iclass;
        logic [PC_W-1:0]   target;
        logic              skip_taken;
        alu_op_type        op;
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] b;
        logic              carry_in;
        logic              to_mem;
    } instr_type;
    // alu result with flags
    typedef struct packed {
        logic              valid;
        logic              to_mem;
        logic [DATA_W-1:0] data;
        logic              carry;
        logic              aux;
        logic              zero;
        logic              ovf;
    } alu_out_type;
endpackage : seq_pkg

// ==== core/stack_mem.sv ====
// four-entry return address memory with registered read
`timescale 1ns/1ps
`default_nettype none
module stack_mem (
    // clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_sys_rst,
    // write side
    input  wire logic                      i_wr,
    input  wire logic [seq_pkg::SP_W-1:0]  i_wr_addr,
    input  wire logic [seq_pkg::PC_W-1:0]  i_wr_data,
    // read side
    input  wire logic [seq_pkg::SP_W-1:0]  i_rd_addr,
    output logic      [seq_pkg::PC_W-1:0]  o_rd_data
);
    import seq_pkg::*;

    // whole state: entries and read register
    typedef struct packed {
        logic [STACK_LEVELS-1:0][PC_W-1:0] mem;
        logic [PC_W-1:0]                   rd;
    } mem_state_type;

    mem_state_type st;       // registered state
    mem_state_type next_st;  // next state

    // write one entry, read another into the register
    always_comb begin
        next_st = st;
        if (i_wr) begin
            next_st.mem[i_wr_addr] = i_wr_data;
        end
        next_st.rd = st.mem[i_rd_addr];
    end

    // register the state
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rd_data = st.rd;
endmodule : stack_mem
`default_nettype wire

// ==== core/alu_unit.sv ====
// 8-bit arithmetic and logic unit with status flags
`timescale 1ns/1ps
`default_nettype none
module alu_unit (
    // operation and operands
    input  wire seq_pkg::alu_op_type            i_op,
    input  wire logic [seq_pkg::DATA_W-1:0]     i_a,
    input  wire logic [seq_pkg::DATA_W-1:0]     i_b,
    input  wire logic                           i_carry,
    // result and flags
    output logic      [seq_pkg::DATA_W-1:0]     o_data,
    output logic                                o_carry,
    output logic                                o_aux,
    output logic                                o_ovf
);
    import seq_pkg::*;

    // combinational operation select
    always_comb begin
        logic [DATA_W:0] sum;  // nine-bit sum with carry
        logic [4:0]      low;  // nibble sum for aux carry
        sum     = '0;
        low     = '0;
        o_data  = i_a;
        o_carry = i_carry;
        o_aux   = 1'b0;
        o_ovf   = 1'b0;
        case (i_op)
            ALU_ADD, ALU_ADC: begin
                // add, optionally with carry
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, (i_op == ALU_ADC) & i_carry};
                low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]}
                    + {4'h0, (i_op == ALU_ADC) & i_carry};
                o_data  = sum[DATA_W-1:0];
                o_carry = sum[DATA_W];
                o_aux   = low[4];
                o_ovf   = (i_a[7] == i_b[7]) && (o_data[7] != i_a[7]);
            end
            ALU_SUB, ALU_SBC: begin
                // subtract; carry set means no borrow
                sum = {1'b0, i_a} + {1'b0, ~i_b}
                    + {8'h00, (i_op == ALU_SUB) | i_carry};
                low = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]}
                    + {4'h0, (i_op == ALU_SUB) | i_carry};
                o_data  = sum[DATA_W-1:0];
                o_carry = sum[DATA_W];
                o_aux   = low[4];
                o_ovf   = (i_a[7] != i_b[7]) && (o_data[7] != i_a[7]);
            end
            ALU_DAA: begin
                // decimal adjust of the accumulator
                sum = {1'b0, i_a};
                if (i_a[3:0] > 4'h9) begin
                    sum = sum + 9'h006;
                end
                if ((sum[7:4] > 4'h9) || i_carry || sum[8]) begin
                    sum = sum + 9'h060;
                end
                o_data  = sum[DATA_W-1:0];
                o_carry = sum[DATA_W] | i_carry;
            end
            ALU_AND: o_data = i_a & i_b;             // logic and
            ALU_OR:  o_data = i_a | i_b;             // logic or
            ALU_XOR: o_data = i_a ^ i_b;             // logic xor
            ALU_CPL: o_data = ~i_a;                  // complement
            ALU_RR:  o_data = {i_a[0], i_a[7:1]};    // rotate right
            ALU_RL:  o_data = {i_a[6:0], i_a[7]};    // rotate left
            ALU_RRC: begin
                // rotate right through carry
                o_data  = {i_carry, i_a[7:1]};
                o_carry = i_a[0];
            end
            ALU_RLC: begin
                // rotate left through carry
                o_data  = {i_a[6:0], i_carry};
                o_carry = i_a[7];
            end
            ALU_INC: o_data = i_a + 8'h01;           // increment
            ALU_DEC: o_data = i_a - 8'h01;           // decrement
            default: o_data = i_a;                   // pass through
        endcase
    end
endmodule : alu_unit
`default_nettype wire

// ==== tb/prog_mem_model.sv ====
// program memory model that hands fetched words to the sequencer
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    // clock
    input  wire logic                      i_clk_sys,
    // fetch request from the sequencer
    input  wire logic [seq_pkg::PC_W-1:0]  i_addr,
    input  wire logic                      i_fetch,
    // word under execution and its address
    output seq_pkg::instr_type             o_instr,
    output logic      [seq_pkg::PC_W-1:0]  o_exec_addr
);
    import seq_pkg::*;
    instr_type       prog [0:2047]; // decoded program image, loaded by the bench
    instr_type       held;          // word fetched in this instruction cycle
    logic [PC_W-1:0] held_addr;     // address of that word
    // blank image and idle outputs at time zero
    initial begin
        for (int i = 0; i < 2048; i++) begin
            prog[i] = '0;
        end
        held        = '0;
        held_addr   = '0;
        o_instr     = '0;
        o_exec_addr = '0;
    end
    // word fetched in one cycle is executed in the next
    always @(posedge i_clk_sys) begin
        if (i_fetch === 1'b1) begin
            o_instr     <= held;
            o_exec_addr <= held_addr;
            held        <= prog[i_addr];
            held_addr   <= i_addr;
        end
    end
endmodule : prog_mem_model
`default_nettype wire

// ==== tb/tb_cpu_fetch_sequencer_stack.sv ====
// self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHECK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module tb_cpu_fetch_sequencer_stack;
    import seq_pkg::*;
    localparam logic [PC_W-1:0] VEC = 11'h7f0; // interrupt entry used throughout
    logic            i_clk_sys   = 1'b0;  // system clock
    logic            i_sys_rst   = 1'b1;  // synchronous reset
    logic            i_int_req   = 1'b0;  // interrupt request pulse
    logic [7:0]      i_reg_addr  = 8'h00; // register port address
    logic [7:0]      i_reg_wdata = 8'h00; // register port write data
    logic            i_reg_wr    = 1'b0;  // write strobe
    logic            i_reg_rd    = 1'b0;  // read strobe
    logic [PC_W-1:0] o_prog_addr, exec_addr;
    logic            o_fetch, o_dummy_cycle, o_int_ack, o_stack_overflow;
    logic [7:0]      o_reg_rdata, rd;
    phase_type       o_phase;
    instr_type       i_instr, w;
    alu_out_type     o_alu;
    int              mismatches = 0, samples_checked = 0, idx = 0, gap = 0, acks = 0, ovfs = 0;
    logic [PC_W-1:0] exp_addr [0:17] = '{11'h000, 11'h001, 11'h002, 11'h0f0, 11'h0f2, 11'h200,
        11'h300, 11'h400, 11'h500, 11'h501, 11'h600, 11'h502, VEC, 11'h503, 11'h504, 11'h505,
        11'h540, 11'h541};
    int              exp_gap [0:17] = '{0, 4, 4, 8, 8, 8, 8, 8, 8, 4, 8, 8, 8, 8, 4, 4, 8, 4};
    // clock at 100 MHz
    always #5 i_clk_sys = ~i_clk_sys;
    cpu_fetch_sequencer_stack dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .o_prog_addr(o_prog_addr), .o_fetch(o_fetch), .o_phase(o_phase),
        .o_dummy_cycle(o_dummy_cycle), .i_instr(i_instr), .i_int_req(i_int_req),
        .i_int_vector(VEC), .o_int_ack(o_int_ack), .o_stack_overflow(o_stack_overflow),
        .o_alu(o_alu), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
    prog_mem_model mem (.i_clk_sys(i_clk_sys), .i_addr(o_prog_addr), .i_fetch(o_fetch),
        .o_instr(i_instr), .o_exec_addr(exec_addr));
    // trace of executed words: address and spacing in clocks
    always @(posedge i_clk_sys) begin
        gap = gap + 1;
        if (i_sys_rst === 1'b0 && o_phase === PH_T4 && o_dummy_cycle === 1'b0 && idx < 18) begin
            `CHECK(exec_addr, exp_addr[idx])
            if (idx > 0) `CHECK(gap, exp_gap[idx])
            gap = 0;
            idx = idx + 1;
        end
        if (o_alu.valid === 1'b1) `CHECK(o_alu, 14'h2805)
        if (o_int_ack === 1'b1) acks = acks + 1;
        if (o_stack_overflow === 1'b1) ovfs = ovfs + 1;
    end
    // closing report
    task automatic print_verdict;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // bounded wait for a trace position
    task automatic wait_idx(input int n);
        for (int k = 0; k < 400 && idx < n; k++) begin
            @(negedge i_clk_sys);
        end
        if (idx < n) begin
            mismatches++;
            print_verdict();
        end
    endtask : wait_idx
    // one-cycle register access; read data sampled in the cycle after
    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_wr    <= wr;
        i_reg_rd    <= ~wr;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        rd = o_reg_rdata;
    endtask : reg_access
    // place one word of a given class and target in the image
    task automatic put(input logic [PC_W-1:0] a, input iclass_type c, input logic [PC_W-1:0] t);
        w = '0;
        w.iclass = c;
        w.target = t;
        w.skip_taken = (c == I_SKIP);
        mem.prog[a] = w;
    endtask : put
    // main sequence
    initial begin
        repeat (2) @(negedge i_clk_sys);
        `CHECK({o_phase, o_dummy_cycle, o_prog_addr}, {PH_T1, 1'b1, 11'h000})
        put(11'h002, I_JUMP, 11'h0f0);
        put(11'h0f0, I_SKIP, 11'h000);
        put(11'h0f2, I_CALL, 11'h200);
        put(11'h200, I_CALL, 11'h300);
        put(11'h300, I_CALL, 11'h400);
        put(11'h400, I_CALL, 11'h500);
        put(11'h501, I_CALL, 11'h600);
        put(11'h600, I_RET, 11'h000);
        put(VEC, I_INTERRUPT_RETURN, 11'h000);
        put(11'h001, I_ALU, 11'h000);
        mem.prog[11'h001].a = 8'h7f;
        mem.prog[11'h001].b = 8'h01;
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        // request while the stack is full: must wait for a return
        wait_idx(9);
        @(posedge i_clk_sys);
        i_int_req <= 1'b1;
        @(posedge i_clk_sys);
        i_int_req <= 1'b0;
        // short jump through the low byte of the counter
        wait_idx(15);
        reg_access(1'b1, ADDR_PCL, 8'h40);
        reg_access(1'b0, 8'h7e, 8'h00);
        `CHECK(rd, 8'h00)
        reg_access(1'b0, ADDR_PCL, 8'h00);
        `CHECK(rd, 8'h41)
        reg_access(1'b0, ADDR_STATUS, 8'h00);
        `CHECK(rd, 8'h04)
        wait_idx(18);
        `CHECK(acks, 1)
        `CHECK(ovfs, 1)
        print_verdict();
    end
endmodule : tb_cpu_fetch_sequencer_stack
`default_nettype wire
